// [hdl/mci_pkg.sv]
// Shared constants, types and register map of the motion command bit interpreter.
// Assumes a single APB clock domain; the motion generator sits on the same clock.
package mci_pkg;

  // ==========================================================================
  // Register map
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CMD_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD_DATA = 8'h04;
  localparam logic [7:0] OFS_RESP_STAT = 8'h08;
  localparam logic [7:0] OFS_RESP_DATA = 8'h0c;
  localparam logic [7:0] OFS_CFG = 8'h10;
  localparam logic [7:0] OFS_JOG0 = 8'h14;
  localparam logic [7:0] OFS_JOG1 = 8'h18;
  localparam logic [7:0] OFS_JOG2 = 8'h1c;
  localparam logic [7:0] OFS_JOG3 = 8'h20;
  localparam logic [7:0] OFS_MSTATE = 8'h24;

  // ==========================================================================
  // Field positions inside the command and response words
  localparam int unsigned LAUNCH_BIT = 0;
  localparam int unsigned MODE_BIT = 7;
  localparam int unsigned CODE_LSB = 8;
  localparam int unsigned RTYPE_LSB = 12;
  localparam int unsigned BYTE1_LSB = 8;
  localparam int unsigned BYTE2_LSB = 16;
  localparam int unsigned BYTE3_LSB = 24;
  localparam int unsigned REL_BIT = 24;
  localparam int unsigned REV_BIT = 25;
  localparam int unsigned CFG_SPEED_BIT = 0;
  localparam int unsigned CFG_HOME_LSB = 4;
  localparam int unsigned REQ_W = 9;

  // ==========================================================================
  // Values
  localparam logic [31:0] JOG_DIST_RST = 32'h0000_0100;
  localparam logic [31:0] OVR_MAX = 32'h0000_00c8;
  localparam logic [3:0] CODE_NOP = 4'h0;
  localparam logic [3:0] RT_CMD_POS = 4'h0;
  localparam logic [3:0] RT_CUR_POS = 4'h1;
  localparam logic [3:0] RT_POS_ERR = 4'h2;
  localparam logic [3:0] RT_CMD_SPD = 4'h3;
  localparam logic [3:0] RT_CUR_SPD = 4'h4;
  localparam logic [3:0] RT_TORQUE = 4'h5;
  localparam logic [3:0] RT_STATION = 4'ha;
  localparam logic [3:0] RT_TABLE = 4'hb;

  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_MOVE = 4'b0010,
    ST_HOLD = 4'b0100,
    ST_STOP = 4'b1000
  } mci_state_e;

  typedef enum logic [2:0] {
    MK_NONE = 3'h0,
    MK_POS = 3'h1,
    MK_FEED = 3'h2,
    MK_JOG = 3'h3,
    MK_STATION = 3'h4,
    MK_TABLE = 3'h5,
    MK_HOME = 3'h6
  } mci_kind_e;

  // Byte 2 of a move command, bit 7 first.
  typedef struct packed {
    logic home;
    logic table_move;
    logic station;
    logic jog;
    logic feed;
    logic zero;
    logic pause;
    logic abort;
  } mci_req_s;

  typedef struct packed {
    logic start;
    logic stop;
    logic hold;
    mci_kind_e kind;
    logic reverse;
    logic relative;
    logic speed_abs;
    logic [31:0] data;
  } mci_mg_cmd_s;

  typedef struct packed {
    logic active;
    logic settled;
    logic near;
    logic home_zone;
  } mci_mg_stat_s;

  typedef struct packed {
    logic [31:0] cmd_pos;
    logic [31:0] cur_pos;
    logic [31:0] pos_err;
    logic [31:0] cmd_spd;
    logic [31:0] cur_spd;
    logic [31:0] torque;
    logic [31:0] station;
    logic [31:0] table_no;
  } mci_pos_s;

endpackage : mci_pkg

// [hdl/mci_edge.sv]
// Edge detector for the request bits of one command message.
// Assumes level is stable whenever sample pulses.
`timescale 1ns/1ps
`default_nettype none
module mci_edge #(
  parameter int unsigned W = 9
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sample,
  input wire logic [W-1:0] level,
  output logic valid,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  typedef struct packed {
    logic valid;
    logic [W-1:0] prev;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
  } mci_edge_s;

  mci_edge_s q, n;

  // Edges are taken against the previous message only, so each edge acts once.
  always_comb begin
    n = q;
    n.valid = sample;
    n.rise = '0;
    n.fall = '0;
    if (sample) begin
      n.rise = level & ~q.prev; // [RL20]
      n.fall = ~level & q.prev;
      n.prev = level;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign valid = q.valid;
  assign rise = q.rise;
  assign fall = q.fall;
endmodule : mci_edge
`default_nettype wire

// [hdl/mci_resp_mux.sv]
// Selects the response data word from the motion generator's figures.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module mci_resp_mux
  import mci_pkg::*;
(
  input wire logic [3:0] rtype,
  input wire mci_pos_s pos,
  output logic [31:0] data
);
  always_comb begin
    unique case (rtype)
      RT_CMD_POS: data = pos.cmd_pos; // [RL19]
      RT_CUR_POS: data = pos.cur_pos;
      RT_POS_ERR: data = pos.pos_err;
      RT_CMD_SPD: data = pos.cmd_spd;
      RT_CUR_SPD: data = pos.cur_spd;
      RT_TORQUE: data = pos.torque;
      RT_STATION: data = pos.station;
      RT_TABLE: data = pos.table_no;
      default: data = '0;
    endcase
  end
endmodule : mci_resp_mux
`default_nettype wire

// [hdl/mci_top.sv]
// Motion command bit interpreter: APB register slave, request decoder and response builder.
// Assumes the motion generator runs on pclk and raises mg_stat.active within a few cycles
// of a start pulse; limit inputs come from pins and are synchronised here.
//
// Contract
// [RL1] Pause bit set in a move holds the axis; clearing it resumes the move.
// [RL2] A held move reports progress 1 and the settled flag from the axis.
// [RL3] Feed bit rising starts constant travel; falling decelerates to rest.
// [RL4] Feed data is override 0..200 percent, or the speed itself when selected.
// [RL5] Jog bit rising moves jog distance; early fall stops and discards remainder.
// [RL6] Jog selector 0..3 picks one of four jog distance settings.
// [RL7] Station bit rising travels to station; falling stops and discards remainder.
// [RL8] Table bit rising runs point-table entry; falling stops and discards remainder.
// [RL9] Home bit rising starts origin return; falling ends it; no later resume.
// [RL10] Relative bit: 0 absolute, 1 incremental, for station, table and positioning.
// [RL11] Reverse bit: 0 forward, 1 reverse; ignored for ordinary positioning. Table and home moves here always drive reverse 0.
// [RL12] Response byte 2 holds echoes, a zero, pause echo and progress flag.
// [RL13] Response byte 3 holds limits, settled, near, home zone, zero, echoes.
// [RL14] Progress flag is 1 while moving, 0 on completion or stop request.
// [RL15] Pause echo is 1 on pause request and stays while pause lasts.
// [RL16] Feed echo mirrors the feed request even when travel cannot happen.
// [RL17] Host lays out request bits of bytes 2 and 3 in the fixed order.
// [RL18] Abort bit stops the move, discards remainder, progress goes 0.
// [RL19] Response data word is chosen by the 4-bit response type.
// [RL20] Request edges compare against the previous message, acting once per edge.
// [RL21] Jog, station, table and home echoes mirror their request bits.
`timescale 1ns/1ps
`default_nettype none
module mci_top
  import mci_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mci_mg_stat_s mg_stat,
  input wire mci_pos_s mg_pos,
  input wire logic pos_limit_pin,
  input wire logic neg_limit_pin,
  output mci_mg_cmd_s mg_cmd
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [31:0] cmd_ctrl;
    logic [31:0] cmd_data;
    logic commit;
    logic speed_abs;
    logic [3:0] home_mode;
    logic [3:0][31:0] jog;
    mci_state_e st;
    logic progress;
    logic seen;
    logic home_blk;
    mci_mg_cmd_s mg;
    logic [1:0] plim;
    logic [1:0] nlim;
    logic [31:0] resp_stat;
    logic [31:0] resp_data;
    logic ready;
    logic err;
    logic [31:0] rdata;
  } mci_top_s;

  mci_top_s q, n;
  mci_req_s req;
  mci_req_s rise_r;
  logic ev;
  logic launch_rise;
  logic [REQ_W-1:0] rise_v;
  logic [31:0] mux_data;
  logic rev;
  logic rel;
  logic [3:0] code;

  assign req = mci_req_s'(q.cmd_ctrl[BYTE2_LSB +: 8]);
  assign rev = q.cmd_ctrl[REV_BIT];
  assign rel = q.cmd_ctrl[REL_BIT];
  assign code = q.cmd_ctrl[CODE_LSB +: 4];
  assign rise_r = mci_req_s'(rise_v[7:0]);
  assign launch_rise = rise_v[8];

  mci_edge #(.W(REQ_W)) u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .sample(q.commit),
    .level({q.cmd_ctrl[LAUNCH_BIT], q.cmd_ctrl[BYTE2_LSB +: 8]}),
    .valid(ev),
    .rise(rise_v),
    .fall()
  );

  mci_resp_mux u_mux (
    .rtype(q.cmd_ctrl[RTYPE_LSB +: 4]),
    .pos(mg_pos),
    .data(mux_data)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic mci_mg_cmd_s launch(input mci_kind_e k, input logic rv, input logic rl,
                                         input logic sa, input logic [31:0] d);
    mci_mg_cmd_s c;
    c = '0;
    c.start = 1'b1;
    c.kind = k;
    c.reverse = rv;
    c.relative = rl;
    c.speed_abs = sa;
    c.data = d;
    return c;
  endfunction : launch

  // The request bit that keeps the current move alive; ordinary positioning has none.
  function automatic logic own_level(input mci_kind_e k, input mci_req_s r);
    unique case (k)
      MK_FEED: return r.feed;
      MK_JOG: return r.jog;
      MK_STATION: return r.station;
      MK_TABLE: return r.table_move;
      MK_HOME: return r.home;
      default: return 1'b1;
    endcase
  endfunction : own_level

  // ==========================================================================
  // Next state
  always_comb begin
    logic hit;
    logic acc;
    logic [31:0] rd;
    logic [31:0] ovr;
    hit = 1'b1;
    acc = psel & penable & q.ready;
    rd = '0;
    ovr = q.cmd_data;
    n = q;
    n.commit = 1'b0;
    n.mg.start = 1'b0;
    n.mg.stop = 1'b0;
    n.plim = {q.plim[0], pos_limit_pin};
    n.nlim = {q.nlim[0], neg_limit_pin};

    // APB: read data is latched in the setup cycle and answered one cycle later.
    unique case (paddr)
      OFS_CMD_CTRL: rd = q.cmd_ctrl;
      OFS_CMD_DATA: rd = q.cmd_data;
      OFS_RESP_STAT: rd = q.resp_stat;
      OFS_RESP_DATA: rd = q.resp_data;
      OFS_CFG: rd = {24'h0, q.home_mode, 3'h0, q.speed_abs};
      OFS_JOG0: rd = q.jog[0];
      OFS_JOG1: rd = q.jog[1];
      OFS_JOG2: rd = q.jog[2];
      OFS_JOG3: rd = q.jog[3];
      OFS_MSTATE: rd = {20'h0, q.home_blk, q.mg.kind, q.progress, 3'h0, q.st};
      default: hit = 1'b0;
    endcase
    n.ready = psel & ~penable;
    if (psel && !penable) begin
      n.rdata = hit ? rd : 32'h0;
      n.err = ~hit;
    end
    if (acc && pwrite && !q.err) begin
      unique case (paddr)
        OFS_CMD_CTRL: begin
          // A write here closes one command message cycle.
          n.cmd_ctrl = merge(q.cmd_ctrl, pwdata, pstrb);
          n.commit = 1'b1;
        end
        OFS_CMD_DATA: n.cmd_data = merge(q.cmd_data, pwdata, pstrb);
        OFS_CFG: begin
          if (pstrb[0]) begin
            n.speed_abs = pwdata[CFG_SPEED_BIT];
            n.home_mode = pwdata[CFG_HOME_LSB +: 4];
          end
        end
        OFS_JOG0: n.jog[0] = merge(q.jog[0], pwdata, pstrb);
        OFS_JOG1: n.jog[1] = merge(q.jog[1], pwdata, pstrb);
        OFS_JOG2: n.jog[2] = merge(q.jog[2], pwdata, pstrb);
        OFS_JOG3: n.jog[3] = merge(q.jog[3], pwdata, pstrb);
        default: n.err = q.err;
      endcase
    end

    if (q.cmd_data > OVR_MAX) begin
      ovr = OVR_MAX; // [RL4]
    end

    // ========================================================================
    // Motion sequencing
    unique case (q.st)
      ST_IDLE: begin
        if (ev && !req.abort) begin
          n.st = ST_MOVE;
          n.progress = 1'b1; // [RL14]
          n.seen = 1'b0;
          n.home_blk = 1'b0;
          if (rise_r.home) begin
            // A return cut short by its home bit falling is not picked up again by a later edge before another move starts.
            n.home_blk = q.home_blk;
            n.mg = launch(MK_HOME, 1'b0, 1'b0, 1'b0, {28'h0, q.home_mode}); // [RL9]
            if (q.home_blk) begin
              n.mg = q.mg;
              n.mg.start = 1'b0;
              n.st = ST_IDLE;
              n.progress = 1'b0;
            end
          end else if (rise_r.table_move) begin
            n.mg = launch(MK_TABLE, 1'b0, rel, 1'b0, q.cmd_data); // [RL8] [RL10]
          end else if (rise_r.station) begin
            n.mg = launch(MK_STATION, rev, rel, 1'b0, q.cmd_data); // [RL7] [RL11]
          end else if (rise_r.jog) begin
            n.mg = launch(MK_JOG, rev, 1'b0, 1'b0, q.jog[q.cmd_data[1:0]]); // [RL5] [RL6]
          end else if (rise_r.feed) begin
            n.mg = launch(MK_FEED, rev, 1'b0, q.speed_abs,
                          q.speed_abs ? q.cmd_data : ovr); // [RL3] [RL4]
          end else if (launch_rise && code != CODE_NOP) begin
            n.mg = launch(MK_POS, 1'b0, rel, 1'b0, q.cmd_data); // [RL10] [RL11]
          end else begin
            n.st = ST_IDLE;
            n.progress = 1'b0;
            n.home_blk = q.home_blk;
          end
        end
      end
      ST_MOVE, ST_HOLD: begin
        if (mg_stat.active) begin
          n.seen = 1'b1;
        end
        if (req.abort || !own_level(q.mg.kind, req)) begin
          // Stop request: decelerate and discard what is left.
          n.st = ST_STOP;
          n.mg.stop = 1'b1; // [RL18] [RL3] [RL5] [RL7] [RL8] [RL9]
          n.mg.hold = 1'b0;
          n.progress = 1'b0; // [RL14]
          n.home_blk = (q.mg.kind == MK_HOME) && !req.abort;
        end else if (req.pause) begin
          n.st = ST_HOLD;
          n.mg.hold = 1'b1; // [RL1] [RL2]
        end else if (q.st == ST_HOLD) begin
          n.st = ST_MOVE;
          n.mg.hold = 1'b0; // [RL1]
        end else if (q.seen && !mg_stat.active) begin
          n.st = ST_IDLE;
          n.progress = 1'b0; // [RL14]
        end
      end
      ST_STOP: begin
        if (!mg_stat.active) begin
          n.st = ST_IDLE;
        end
      end
    endcase

    // ========================================================================
    // Response words, refreshed every cycle from the held command.
    n.resp_stat = '0;
    n.resp_stat[MODE_BIT] = 1'b0; // [RL13]
    n.resp_stat[BYTE1_LSB +: 8] = q.cmd_ctrl[BYTE1_LSB +: 8];
    n.resp_stat[BYTE2_LSB +: 8] = {req.home, req.table_move, req.station, req.jog, req.feed,
                                   1'b0, req.pause, q.progress}; // [RL12] [RL15] [RL16] [RL21]
    n.resp_stat[BYTE3_LSB +: 8] = {q.plim[1], q.nlim[1], mg_stat.settled, mg_stat.near,
                                   mg_stat.home_zone, 1'b0, rev, rel}; // [RL13]
    n.resp_data = mux_data; // [RL19]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.jog <= {4{JOG_DIST_RST}};
    end else begin
      q <= n;
    end
  end

  assign prdata = q.rdata;
  assign pready = q.ready;
  assign pslverr = q.err;
  assign mg_cmd = q.mg;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  hold_drives_axis_a: assert property (q.st == ST_HOLD |-> q.mg.hold && q.progress) // [RL1]
    else $error("hold state without hold output");
  hold_resume_a: assert property (q.st == ST_HOLD && !req.pause && !req.abort
      && own_level(q.mg.kind, req) |=> q.st == ST_MOVE && !q.mg.hold) // [RL1]
    else $error("pause release did not resume");
  feed_start_a: assert property (q.st == ST_IDLE && ev && !req.abort
      && rise_v == 9'h008 |=> q.mg.start && q.mg.kind == MK_FEED
      && q.mg.reverse == $past(rev)) // [RL3]
    else $error("feed edge did not start feed");
  feed_drop_a: assert property (q.st == ST_MOVE && q.mg.kind == MK_FEED && !req.feed
      |=> q.mg.stop && !q.progress ##1 !q.mg.stop) // [RL3]
    else $error("feed fall did not stop");
  override_cap_a: assert property (q.mg.start && q.mg.kind == MK_FEED && !q.mg.speed_abs
      |-> q.mg.data <= OVR_MAX) // [RL4]
    else $error("override above limit");
  jog_select_a: assert property (q.mg.start && q.mg.kind == MK_JOG
      |-> q.mg.data == $past(q.jog[q.cmd_data[1:0]])) // [RL6]
    else $error("wrong jog distance");
  abort_stop_a: assert property ((q.st == ST_MOVE || q.st == ST_HOLD) && req.abort
      |=> q.st == ST_STOP && q.mg.stop && !q.progress) // [RL18]
    else $error("abort did not stop");
  echo_byte_a: assert property (1 |=> q.resp_stat[23:19] == $past(q.cmd_ctrl[23:19])
      && q.resp_stat[17] == $past(req.pause) && !q.resp_stat[18]) // [RL12]
    else $error("byte 2 echo mismatch");
  byte_zero_a: assert property (!q.resp_stat[MODE_BIT] && !q.resp_stat[26]) // [RL13]
    else $error("reserved response bit set");
  start_progress_a: assert property (q.mg.start |-> q.progress && q.st == ST_MOVE) // [RL14]
    else $error("start without progress");
  home_block_a: assert property (q.home_blk && q.st == ST_IDLE && ev && !req.abort
      && rise_v == 9'h080 |=> !q.mg.start) // [RL9]
    else $error("cut origin return resumed");
  resp_station_a: assert property (q.cmd_ctrl[RTYPE_LSB +: 4] == RT_STATION
      |=> q.resp_data == $past(mg_pos.station)) // [RL19]
    else $error("response data not station");

  feed_run_c: cover property (q.mg.start && q.mg.kind == MK_FEED ##[1:50] q.mg.stop);
  hold_cycle_c: cover property (q.st == ST_HOLD ##[1:50] q.st == ST_MOVE);
  abort_move_c: cover property (q.st == ST_MOVE && req.abort);
  jog_done_c: cover property (q.mg.kind == MK_JOG && q.st == ST_MOVE ##1 q.st == ST_IDLE);
endmodule : mci_top
`default_nettype wire

// [sim/mci_mg_model.sv]
// Stand-in for the motion generator behind the interpreter.
// Assumes mg_cmd on pclk; a move runs RUN cycles, feed runs until stopped.
`timescale 1ns/1ps
`default_nettype none
module mci_mg_model
  import mci_pkg::*;
#(
  parameter int unsigned RUN = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire mci_mg_cmd_s mg_cmd,
  output mci_mg_stat_s mg_stat,
  output mci_pos_s mg_pos
);
  logic [7:0] run_q;
  logic feed_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 8'h00;
      feed_q <= 1'b0;
    end else if (mg_cmd.start) begin
      run_q <= 8'(RUN);
      feed_q <= (mg_cmd.kind == MK_FEED);
    end else if (mg_cmd.stop) begin
      // A stop drops what is left and only lets the deceleration run out.
      run_q <= (run_q > 8'h02) ? 8'h02 : run_q;
      feed_q <= 1'b0;
    end else if (run_q != 8'h00 && !mg_cmd.hold && !feed_q) begin
      run_q <= run_q - 8'h01;
    end
  end
  assign mg_stat.active = (run_q != 8'h00);
  // While held the axis is at rest, so it reports settled.
  assign mg_stat.settled = (run_q == 8'h00) || mg_cmd.hold;
  assign mg_stat.near = (run_q < 8'h04);
  assign mg_stat.home_zone = 1'b0;
  assign mg_pos = '{32'h5a00_0000, 32'h5a00_0001, 32'h5a00_0002, 32'h5a00_0003,
                    32'h5a00_0004, 32'h5a00_0005, 32'h5a00_0006, 32'h5a00_0007};
endmodule : mci_mg_model
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench: APB master tasks and command message sequences.
// Assumes mci_top and the motion generator stand-in on one 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mci_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pos_limit_pin = 1'b0;
  logic neg_limit_pin = 1'b0;
  mci_mg_stat_s mg_stat;
  mci_pos_s mg_pos;
  mci_mg_cmd_s mg_cmd;
  mci_mg_cmd_s last_q;
  int err_total = 0;
  int total_checks = 0;
  int starts = 0;
  int stops = 0;
  logic [31:0] rd;
  logic er;
  logic [3:0] rts [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'ha, 4'hb};
  always #4 pclk = ~pclk;
  mci_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mg_stat(mg_stat), .mg_pos(mg_pos),
    .pos_limit_pin(pos_limit_pin), .neg_limit_pin(neg_limit_pin), .mg_cmd(mg_cmd));
  mci_mg_model i_mg (.pclk(pclk), .presetn(presetn), .mg_cmd(mg_cmd),
    .mg_stat(mg_stat), .mg_pos(mg_pos));
  always @(posedge pclk) begin
    if (mg_cmd.start === 1'b1) begin
      last_q <= mg_cmd;
      starts <= starts + 1;
    end
    if (mg_cmd.stop === 1'b1) stops <= stops + 1;
  end
  // ==========================================================================
  // Tasks
  task automatic complete_run(input bit f);
    if (f) err_total++;
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check
  // Pready, read data and error are taken at the rising edge that ends the access phase.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic done;
    done = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20 && !done; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        rd = prdata;
        er = pslverr;
        done = 1'b1;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (!done) complete_run(1);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask : rchk
  task automatic wait_new(input logic s, input int prev);
    int n;
    for (n = 0; n < 30; n++) begin
      @(posedge pclk);
      if ((s ? stops : starts) != prev) break;
    end
    if (n == 30) complete_run(1);
  endtask : wait_new
  task automatic wait_idle();
    int n;
    for (n = 0; n < 100; n++) begin
      apb(1'b0, OFS_MSTATE, 32'h0);
      if (rd[0] === 1'b1) break;
    end
    if (n == 100) complete_run(1);
  endtask : wait_idle
  task automatic go(input logic [31:0] c, input logic [31:0] d);
    int p;
    p = starts;
    wr(OFS_CMD_DATA, d);
    wr(OFS_CMD_CTRL, c);
    wait_new(1'b0, p);
  endtask : go
  task automatic halt(input logic [31:0] c);
    int p;
    p = stops;
    wr(OFS_CMD_CTRL, c);
    wait_new(1'b1, p);
    wait_idle();
  endtask : halt
  // ==========================================================================
  // Sequence
  initial begin
    int k;
    int m;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(OFS_JOG0, JOG_DIST_RST, 32'hffff_ffff);
    apb(1'b0, 8'h28, 32'h0);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
    pos_limit_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    rchk(OFS_RESP_STAT, 32'h8000_0000, 32'hc000_00ff);
    pos_limit_pin <= 1'b0;
    // Override above the ceiling must come out clamped.
    go(32'h0208_0000, 32'h0000_00fa);
    check(32'(last_q.kind), 32'(MK_FEED));
    check(32'(last_q.reverse), 32'h1);
    check(last_q.data, OVR_MAX);
    rchk(OFS_RESP_STAT, 32'h0209_0000, 32'h070d_0000);
    halt(32'h0200_0000);
    rchk(OFS_RESP_STAT, 32'h0200_0000, 32'h0209_0000);
    wr(OFS_CFG, 32'h1);
    go(32'h0008_0000, 32'h0000_0400);
    check(last_q.data, 32'h0000_0400);
    check(32'(last_q.speed_abs), 32'h1);
    halt(32'h0);
    for (k = 0; k < 4; k++) begin
      wr(OFS_JOG0 + 8'(4 * k), 32'h10 + k);
      go(32'h0010_0000, k);
      check(last_q.data, 32'h10 + k);
      check(32'(last_q.kind), 32'(MK_JOG));
      rchk(OFS_RESP_STAT, 32'h0011_0000, 32'h0311_0000);
      halt(32'h0);
    end
    // A repeated level without an edge starts nothing, even once the jog has ended.
    go(32'h0010_0000, 32'h0);
    wait_idle();
    m = starts;
    wr(OFS_CMD_CTRL, 32'h0010_0000);
    repeat (6) @(posedge pclk);
    check(starts, m);
    wr(OFS_CMD_CTRL, 32'h0);
    go(32'h0120_0000, 32'h5);
    check(32'(last_q.kind), 32'(MK_STATION));
    check(32'(last_q.relative), 32'h1);
    check(last_q.data, 32'h5);
    wr(OFS_CMD_CTRL, 32'h0122_0000);
    repeat (4) @(posedge pclk);
    check(32'(mg_cmd.hold), 32'h1);
    rchk(OFS_RESP_STAT, 32'h2123_0000, 32'h2123_0000);
    wr(OFS_CMD_CTRL, 32'h0120_0000);
    repeat (4) @(posedge pclk);
    check(32'(mg_cmd.hold), 32'h0);
    rchk(OFS_RESP_STAT, 32'h0021_0000, 32'h0023_0000);
    halt(32'h0121_0000);
    rchk(OFS_RESP_STAT, 32'h2000_0000, 32'h2001_0000);
    wr(OFS_CMD_CTRL, 32'h0);
    go(32'h0040_0000, 32'h7);
    check(32'(last_q.kind), 32'(MK_TABLE));
    check(32'(last_q.relative), 32'h0);
    check(last_q.data, 32'h7);
    rchk(OFS_RESP_STAT, 32'h0041_0000, 32'h0041_0000);
    halt(32'h0);
    wr(OFS_CFG, 32'h30);
    go(32'h0080_0000, 32'h0);
    check(32'(last_q.kind), 32'(MK_HOME));
    check(last_q.data, 32'h3);
    halt(32'h0);
    m = starts;
    wr(OFS_CMD_CTRL, 32'h0080_0000);
    repeat (6) @(posedge pclk);
    check(starts, m);
    wr(OFS_CMD_CTRL, 32'h0);
    go(32'h0300_0101, 32'h9);
    check(32'(last_q.kind), 32'(MK_POS));
    check(32'(last_q.reverse), 32'h0);
    check(32'(last_q.relative), 32'h1);
    wait_idle();
    rchk(OFS_RESP_STAT, 32'h0, 32'h0001_0000);
    for (k = 0; k < 8; k++) begin
      wr(OFS_CMD_CTRL, 32'(rts[k]) << 12);
      repeat (3) @(posedge pclk);
      rchk(OFS_RESP_DATA, 32'h5a00_0000 + k, 32'hffff_ffff);
    end
    complete_run(0);
  end
endmodule : testbench
`default_nettype wire
